/* rtl/pcx_pkg.sv */
// Behaviour
// - Enabled resources other than UART and CAN take the lowest free pin in fixed priority order.
// - Primary UART transmit sits on P0.4 and receive on P0.5 when enabled.
// - CAN transmit sits on P0.6 and receive on P0.7 when enabled.
// - A pin already given to a resource is passed over for later ones.
// - A pin with its skip bit set counts as already assigned.
// - SMBus, UART, CAN and LIN always claim both of their pins together.
// - SPI takes three pins, four when slave select mode is four-wire.
// - Pins left over act as ordinary general-purpose I/O.
// - With crossbar off every pin is a plain input, routing ignored.
// - Output drivers stay off while the crossbar is disabled.
// - SMBus pins are always open-drain whatever the drive kind bit says.
// - With pull-up disable at 0, open-drain pins get a weak pull-up.
// - The weak pull-up is off while the pin drives low.
// - Input kind 1 is digital, 0 analog; reset leaves all pins digital.
// - Analog pins lose pull-up, output driver and input receiver.
// - Edge capture works on skipped and routed pins, never on analog ones.
// - Route register A bits 0 to 7 enable UART to comparator B async.
// - Route register C holds pull-up disable in bit 7, enable in bit 6.
package pcx_pkg;
  localparam logic [7:0] ADDR_ROUTE_A  = 8'he1;
  localparam logic [7:0] ADDR_ROUTE_C  = 8'hc7;
  localparam logic [7:0] ROUTE_A_RESET = 8'h00;
  localparam logic [7:0] ROUTE_C_RESET = 8'h00;
  localparam logic [7:0] ROUTE_C_WMASK = 8'hc1;
  localparam int BIT_UART      = 0;
  localparam int BIT_CAN       = 1;
  localparam int BIT_SPI       = 2;
  localparam int BIT_SMBUS     = 3;
  localparam int BIT_CMPA      = 4;
  localparam int BIT_CMPA_ASYN = 5;
  localparam int BIT_CMPB      = 6;
  localparam int BIT_CMPB_ASYN = 7;
  localparam int BIT_PUD       = 7;
  localparam int BIT_XBAR_ON   = 6;
  localparam int BIT_LIN       = 0;
  localparam int PIN_UART_TX   = 4;
  localparam int PIN_UART_RX   = 5;
  localparam int PIN_CAN_TX    = 6;
  localparam int PIN_CAN_RX    = 7;
  localparam logic [1:0] SSM_THREE_WIRE = 2'h0;
  // Peripheral signal indices; fixed ones first, then priority order
  localparam int NUM_SIG     = 16;
  localparam int SIG_W       = 4;
  localparam int FLEX_BASE   = 4;
  localparam int NUM_FLEX    = 12;
  localparam int SIG_UART_TX = 0;
  localparam int SIG_UART_RX = 1;
  localparam int SIG_CAN_TX  = 2;
  localparam int SIG_CAN_RX  = 3;
  localparam int SIG_SPI_SCK = 4;
  localparam int SIG_SPI_NSS = 7;
  localparam int SIG_SMB_SDA = 8;
  localparam int SIG_SMB_SCL = 9;
  localparam int SIG_LIN_TX  = 14;
  localparam int SIG_LIN_RX  = 15;
  localparam logic [15:0] SIG_INPUT_ONLY = 16'h800a;
endpackage

/* rtl/pcx_alloc.sv */
`timescale 1ns/1ps
module pcx_alloc #(
  parameter int NUM_PINS = 32,
  parameter int NUM_REQ  = 12,
  parameter int PW       = $clog2(NUM_PINS)
) (
  input  wire logic [NUM_PINS-1:0] taken,
  input  wire logic [NUM_REQ-1:0]  req,
  output logic [NUM_REQ-1:0][PW-1:0] req_pin,
  output logic [NUM_REQ-1:0]       req_ok
);
  logic [NUM_PINS-1:0] used;
  logic                found;

  // Walk requests in priority order, each taking the lowest free pin
  always_comb begin
    used    = taken;
    found   = 1'b0;
    req_pin = '0;
    req_ok  = '0;
    for (int s = 0; s < NUM_REQ; s++) begin
      found = 1'b0;
      if (req[s]) begin
        for (int p = 0; p < NUM_PINS; p++) begin
          if (!found && !used[p]) begin
            req_pin[s] = PW'(p);
            req_ok[s]  = 1'b1;
            used[p]    = 1'b1;
            found      = 1'b1;
          end
        end
      end
    end
  end
endmodule

/* rtl/pcx_priority_pin_crossbar.sv */
`timescale 1ns/1ps
module pcx_priority_pin_crossbar #(
  parameter int NUM_PINS = 32
) (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic [7:0]                    sfr_addr,
  input  wire logic [7:0]                    sfr_wdata,
  input  wire logic                          sfr_wr,
  input  wire logic                          sfr_rd,
  output logic      [7:0]                    sfr_rdata,
  input  wire logic [NUM_PINS-1:0]           pin_skip_mask,
  input  wire logic [NUM_PINS-1:0]           pin_input_kind,
  input  wire logic [NUM_PINS-1:0]           pin_drive_kind,
  input  wire logic [1:0]                    slave_select_mode,
  input  wire logic [NUM_PINS-1:0]           gpio_out,
  output logic      [NUM_PINS-1:0]           gpio_in,
  input  wire logic [pcx_pkg::NUM_SIG-1:0]   periph_out,
  input  wire logic [pcx_pkg::NUM_SIG-1:0]   periph_oe,
  output logic      [pcx_pkg::NUM_SIG-1:0]   periph_in,
  input  wire logic [NUM_PINS-1:0]           pad_in,
  output logic      [NUM_PINS-1:0]           pad_out,
  output logic      [NUM_PINS-1:0]           pad_oe,
  output logic      [NUM_PINS-1:0]           pad_pullup,
  output logic      [NUM_PINS-1:0]           pad_in_en,
  output logic      [NUM_PINS-1:0]           pin_edge
);
  import pcx_pkg::*;

  localparam int PW = $clog2(NUM_PINS);

  logic [7:0]                      peripheral_route_enable_a;
  logic [7:0]                      peripheral_route_enable_c;
  logic [NUM_PINS-1:0]             level_q;

  wire logic                       primary_uart_route;
  wire logic                       can_route;
  wire logic                       spi_route;
  wire logic                       smbus_route;
  wire logic                       lin_route;
  wire logic                       crossbar_on;
  wire logic                       global_pullup_disable;
  wire logic                       four_wire;
  wire logic                       wr_route_a;
  wire logic                       wr_route_c;
  wire logic [7:0]                 next_rdata;
  wire logic [NUM_PINS-1:0]        fixed_taken;
  wire logic [NUM_PINS-1:0]        taken;
  wire logic [NUM_FLEX-1:0]        flex_req;
  wire logic [NUM_FLEX-1:0][PW-1:0] flex_pin;
  wire logic [NUM_FLEX-1:0]        flex_ok_raw;
  wire logic [NUM_FLEX-1:0]        flex_ok;
  wire logic [NUM_PINS-1:0]        pin_level;

  logic [NUM_PINS-1:0]             owned;
  logic [NUM_PINS-1:0][SIG_W-1:0]  owner;
  logic [NUM_PINS-1:0]             next_oe;
  logic [NUM_PINS-1:0]             next_out;
  logic [NUM_PINS-1:0]             next_pull;
  logic [NUM_SIG-1:0]              next_periph_in;
  logic [NUM_PINS-1:0]             open_drain;
  logic [NUM_PINS-1:0]             granted;

  function automatic logic [NUM_PINS-1:0] pin_bit(input int p);
    pin_bit = NUM_PINS'(1) << p;
  endfunction

  function automatic logic is_smbus(input logic [SIG_W-1:0] s);
    is_smbus = (s == SIG_W'(SIG_SMB_SDA)) || (s == SIG_W'(SIG_SMB_SCL));
  endfunction

  // Register decode
  assign wr_route_a = sfr_wr && (sfr_addr == ADDR_ROUTE_A);
  assign wr_route_c = sfr_wr && (sfr_addr == ADDR_ROUTE_C);
  assign next_rdata = (sfr_addr == ADDR_ROUTE_A) ? peripheral_route_enable_a :
                      (sfr_addr == ADDR_ROUTE_C) ? peripheral_route_enable_c : 8'h00;

  // Route enable fields
  assign primary_uart_route    = peripheral_route_enable_a[BIT_UART];
  assign can_route             = peripheral_route_enable_a[BIT_CAN];
  assign spi_route             = peripheral_route_enable_a[BIT_SPI];
  assign smbus_route           = peripheral_route_enable_a[BIT_SMBUS];
  assign lin_route             = peripheral_route_enable_c[BIT_LIN];
  assign crossbar_on           = peripheral_route_enable_c[BIT_XBAR_ON];
  assign global_pullup_disable = peripheral_route_enable_c[BIT_PUD];
  assign four_wire             = slave_select_mode != SSM_THREE_WIRE;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      peripheral_route_enable_a <= ROUTE_A_RESET;
      peripheral_route_enable_c <= ROUTE_C_RESET;
      sfr_rdata                 <= 8'h00;
    end else if (clk_en) begin
      if (wr_route_a) begin
        peripheral_route_enable_a <= sfr_wdata;
      end
      if (wr_route_c) begin
        peripheral_route_enable_c <= sfr_wdata & ROUTE_C_WMASK;
      end
      if (sfr_rd) begin
        sfr_rdata <= next_rdata;
      end
    end
  end

  // Fixed pins for UART and CAN are reserved before priority decoding
  assign fixed_taken = (primary_uart_route ? (pin_bit(PIN_UART_TX) | pin_bit(PIN_UART_RX)) : '0)
                     | (can_route ? (pin_bit(PIN_CAN_TX) | pin_bit(PIN_CAN_RX)) : '0);
  assign taken       = pin_skip_mask | fixed_taken;

  // Requests in priority order, recomputed every cycle from live settings
  assign flex_req[0]  = spi_route;
  assign flex_req[1]  = spi_route;
  assign flex_req[2]  = spi_route;
  assign flex_req[3]  = spi_route && four_wire;
  assign flex_req[4]  = smbus_route;
  assign flex_req[5]  = smbus_route;
  assign flex_req[6]  = peripheral_route_enable_a[BIT_CMPA];
  assign flex_req[7]  = peripheral_route_enable_a[BIT_CMPA_ASYN];
  assign flex_req[8]  = peripheral_route_enable_a[BIT_CMPB];
  assign flex_req[9]  = peripheral_route_enable_a[BIT_CMPB_ASYN];
  assign flex_req[10] = lin_route;
  assign flex_req[11] = lin_route;

  pcx_alloc #(
    .NUM_PINS (NUM_PINS),
    .NUM_REQ  (NUM_FLEX),
    .PW       (PW)
  ) u_alloc (
    .taken   (taken),
    .req     (flex_req),
    .req_pin (flex_pin),
    .req_ok  (flex_ok_raw)
  );

  // Paired resources only appear when both pins were found
  assign flex_ok[3:0]   = flex_ok_raw[3:0];
  assign flex_ok[4]     = flex_ok_raw[4] && flex_ok_raw[5];
  assign flex_ok[5]     = flex_ok_raw[4] && flex_ok_raw[5];
  assign flex_ok[9:6]   = flex_ok_raw[9:6];
  assign flex_ok[10]    = flex_ok_raw[10] && flex_ok_raw[11];
  assign flex_ok[11]    = flex_ok_raw[10] && flex_ok_raw[11];

  // Pin ownership; ownership only exists with the crossbar on
  always_comb begin
    owned = '0;
    owner = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (crossbar_on) begin
        if (primary_uart_route && p == PIN_UART_TX) begin
          owned[p] = 1'b1;
          owner[p] = SIG_W'(SIG_UART_TX);
        end
        if (primary_uart_route && p == PIN_UART_RX) begin
          owned[p] = 1'b1;
          owner[p] = SIG_W'(SIG_UART_RX);
        end
        if (can_route && p == PIN_CAN_TX) begin
          owned[p] = 1'b1;
          owner[p] = SIG_W'(SIG_CAN_TX);
        end
        if (can_route && p == PIN_CAN_RX) begin
          owned[p] = 1'b1;
          owner[p] = SIG_W'(SIG_CAN_RX);
        end
        for (int f = 0; f < NUM_FLEX; f++) begin
          if (flex_ok[f] && flex_pin[f] == PW'(p)) begin
            owned[p] = 1'b1;
            owner[p] = SIG_W'(FLEX_BASE + f);
          end
        end
      end
    end
  end

  // Pad drive, pull-up and peripheral input steering
  always_comb begin
    next_oe        = '0;
    next_out       = '0;
    next_pull      = '0;
    open_drain     = '0;
    next_periph_in = '1;
    for (int p = 0; p < NUM_PINS; p++) begin
      // Unowned pins fall back to general-purpose I/O
      next_out[p]   = owned[p] ? periph_out[owner[p]] : gpio_out[p];
      open_drain[p] = !pin_drive_kind[p] || (owned[p] && is_smbus(owner[p]));
      next_oe[p]    = crossbar_on && pin_input_kind[p]
                    && (owned[p] ? (periph_oe[owner[p]] && !SIG_INPUT_ONLY[owner[p]]) : 1'b1)
                    && (!open_drain[p] || !next_out[p]);
      next_pull[p]  = pin_input_kind[p] && open_drain[p] && !global_pullup_disable
                    && !(next_oe[p] && !next_out[p]);
      if (owned[p]) begin
        next_periph_in[owner[p]] = pin_level[p];
      end
    end
  end

  // Analog pins read zero and never raise an edge
  assign pin_level = pad_in & pin_input_kind;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pad_oe     <= '0;
      pad_out    <= '0;
      pad_pullup <= '0;
      pad_in_en  <= '1;
      gpio_in    <= '0;
      periph_in  <= '1;
      level_q    <= pin_level;
      pin_edge   <= '0;
    end else if (clk_en) begin
      pad_oe     <= next_oe;
      pad_out    <= next_out;
      pad_pullup <= next_pull;
      pad_in_en  <= pin_input_kind;
      gpio_in    <= pin_level;
      periph_in  <= next_periph_in;
      level_q    <= pin_level;
      pin_edge   <= pin_input_kind & (pin_level ^ level_q);
    end
  end

  // Pins handed out by the allocator
  always_comb begin
    granted = '0;
    for (int f = 0; f < NUM_FLEX; f++) begin
      if (flex_ok_raw[f]) begin
        granted = granted | pin_bit(int'(flex_pin[f]));
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Register checks
  a_reset_clears : assert property (disable iff (1'b0)
    reset |=> (peripheral_route_enable_a == 8'h00 && peripheral_route_enable_c == 8'h00
               && pad_oe == '0 && pad_in_en == '1))
    else $error("reset did not clear routing");
  a_route_a_write : assert property (
    (clk_en && !reset && wr_route_a) |=> peripheral_route_enable_a == $past(sfr_wdata))
    else $error("route register a write lost");
  a_route_c_write : assert property (
    (clk_en && !reset && wr_route_c) |=> peripheral_route_enable_c == ($past(sfr_wdata) & ROUTE_C_WMASK))
    else $error("route register c write wrong");
  a_rdata_hold : assert property (
    (clk_en && !reset && !sfr_rd) |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  a_freeze_state : assert property (
    (!clk_en && !reset) |=> $stable(peripheral_route_enable_a) && $stable(pad_oe) && $stable(pad_out))
    else $error("state moved while clock enable low");

  // Routing checks
  a_xbar_off_quiet : assert property (
    (clk_en && !crossbar_on) |=> pad_oe == '0)
    else $error("pad driven while crossbar disabled");
  a_xbar_off_input : assert property (
    !crossbar_on |-> owned == '0)
    else $error("routing active while crossbar disabled");
  a_uart_tx_fixed : assert property (
    (clk_en && crossbar_on && primary_uart_route && pin_input_kind[PIN_UART_TX]
     && pin_drive_kind[PIN_UART_TX] && periph_oe[SIG_UART_TX])
    |=> pad_oe[PIN_UART_TX] && pad_out[PIN_UART_TX] == $past(periph_out[SIG_UART_TX]))
    else $error("uart transmit not on its fixed pin");
  a_uart_rx_fixed : assert property (
    (clk_en && crossbar_on && primary_uart_route)
    |=> periph_in[SIG_UART_RX] == $past(pin_level[PIN_UART_RX]))
    else $error("uart receive not taken from its fixed pin");
  a_can_tx_fixed : assert property (
    (clk_en && crossbar_on && can_route && pin_input_kind[PIN_CAN_TX]
     && pin_drive_kind[PIN_CAN_TX] && periph_oe[SIG_CAN_TX])
    |=> pad_oe[PIN_CAN_TX] && pad_out[PIN_CAN_TX] == $past(periph_out[SIG_CAN_TX]))
    else $error("can transmit not on its fixed pin");
  a_can_rx_fixed : assert property (
    (clk_en && crossbar_on && can_route)
    |=> periph_in[SIG_CAN_RX] == ($past(pad_in[PIN_CAN_RX]) && $past(pin_input_kind[PIN_CAN_RX])))
    else $error("can receive not taken from its fixed pin");
  a_nss_three_wire : assert property (
    !four_wire |-> !flex_ok[SIG_SPI_NSS - FLEX_BASE])
    else $error("slave select routed in three-wire mode");
  a_pair_together : assert property (
    flex_ok[SIG_SMB_SDA - FLEX_BASE] == flex_ok[SIG_SMB_SCL - FLEX_BASE]
    && flex_ok[SIG_LIN_TX - FLEX_BASE] == flex_ok[SIG_LIN_RX - FLEX_BASE])
    else $error("paired resource claimed one pin only");
  a_pair_owned : assert property (
    (crossbar_on && flex_ok[SIG_SMB_SDA - FLEX_BASE])
    |-> owned[flex_pin[SIG_SMB_SCL - FLEX_BASE]] && owner[flex_pin[SIG_SMB_SCL - FLEX_BASE]] == SIG_W'(SIG_SMB_SCL))
    else $error("smbus clock pin not owned with its data pin");
  a_skip_unowned : assert property (
    (owned & pin_skip_mask & ~fixed_taken) == '0)
    else $error("skipped pin given to a resource");

  // Pad checks
  a_smbus_no_high : assert property (
    (clk_en && crossbar_on && smbus_route && flex_ok[SIG_SMB_SDA - FLEX_BASE])
    |=> !(pad_oe[$past(flex_pin[SIG_SMB_SDA - FLEX_BASE])] && pad_out[$past(flex_pin[SIG_SMB_SDA - FLEX_BASE])]))
    else $error("smbus pin driven high");
  a_pullup_low_off : assert property (
    (pad_pullup & pad_oe & ~pad_out) == '0)
    else $error("pull-up on while driving low");
  a_analog_dead : assert property (
    clk_en |=> ((pad_oe | pad_pullup | pad_in_en | pin_edge) & ~$past(pin_input_kind)) == '0)
    else $error("analog pin has digital path active");
  a_pullup_od : assert property (
    clk_en |=> ((~pad_pullup & $past(pin_input_kind & open_drain & ~next_oe)) == '0
               || $past(global_pullup_disable)))
    else $error("open-drain pin missing weak pull-up");
  a_pull_push_pull : assert property (
    (clk_en && !reset) |=> (pad_pullup & ~$past(open_drain)) == '0)
    else $error("push-pull pin has weak pull-up");
  a_in_en_follow : assert property (
    (clk_en && !reset) |=> pad_in_en == $past(pin_input_kind))
    else $error("input receiver not following input kind");
  a_gpio_follow : assert property (
    (clk_en && !reset) |=> ((pad_out ^ $past(gpio_out)) & ~$past(owned)) == '0)
    else $error("unrouted pin does not follow its port latch");
  a_edge_on_change : assert property (
    (clk_en && !reset) |=> (pin_edge & ~$past(pin_level ^ level_q)) == '0)
    else $error("edge flagged without a level change");

  // Allocator checks per request
  for (genvar g = 0; g < NUM_FLEX; g++) begin : g_alloc_chk
    a_lowest_free_pin : assert property (
      flex_ok_raw[g] |-> ((pin_bit(int'(flex_pin[g])) - NUM_PINS'(1)) & ~taken & ~granted) == '0)
      else $error("pin granted above a free lower pin");
    a_skip_not_granted : assert property (
      flex_ok_raw[g] |-> !taken[flex_pin[g]])
      else $error("skipped or fixed pin granted");
    a_full_on_refusal : assert property (
      (flex_req[g] && !flex_ok_raw[g]) |-> (~taken & ~granted) == '0)
      else $error("request refused while a pin was free");
    if (g < NUM_FLEX - 1) begin : g_next
      a_grant_rising : assert property (
        (flex_ok_raw[g] && flex_ok_raw[g + 1]) |-> flex_pin[g] < flex_pin[g + 1])
        else $error("later request given a lower pin");
    end
  end

  c_uart_routed   : cover property (crossbar_on && primary_uart_route && periph_oe[SIG_UART_TX]);
  c_spi_four      : cover property (crossbar_on && flex_ok[SIG_SPI_NSS - FLEX_BASE]);
  c_smbus_pair    : cover property (crossbar_on && flex_ok[SIG_SMB_SDA - FLEX_BASE] && smbus_route);
  c_smbus_starved : cover property (crossbar_on && flex_req[SIG_SMB_SDA - FLEX_BASE] && !flex_ok[SIG_SMB_SDA - FLEX_BASE]);
  c_xbar_rise     : cover property (clk_en && $rose(crossbar_on));
endmodule

/* dv/pcx_pad_model.sv */
`timescale 1ns/1ps
module pcx_pad_model #(
  parameter int N = 32
) (
  input  wire logic         core_clk,
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  input  wire logic [N-1:0] pad_pullup,
  input  wire logic [N-1:0] ext_val,
  input  wire logic [N-1:0] ext_en,
  output logic      [N-1:0] pad_in
);
  logic [N-1:0] flt = '0;
  // Pin driver first, then outside driver, then pull-up; a floating pad wanders
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pullup | flt));
  always @(posedge core_clk) begin
    flt <= ~pad_in;
  end
endmodule

/* dv/priority_pin_crossbar_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if (!((g) === (e))) begin err_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module priority_pin_crossbar_test;
  import pcx_pkg::*;
  logic        core_clk;
  logic        reset     = 1'b1;
  logic        clk_en    = 1'b1;
  logic        sfr_wr    = 1'b0;
  logic        sfr_rd    = 1'b0;
  logic [7:0]  sfr_addr  = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [31:0] skip      = 32'h0;
  logic [31:0] in_kind   = '1;
  logic [31:0] drv_kind  = '1;
  logic [31:0] gpio_out  = '1;
  logic [31:0] ext_val   = 32'h0;
  logic [31:0] ext_en    = 32'h0000ffff;
  logic [1:0]  ssm       = 2'h1;
  logic [15:0] p_out     = '1;
  logic [15:0] p_oe      = '1;
  logic [7:0]  sfr_rdata;
  logic [15:0] periph_in;
  logic [31:0] gpio_in, pad_in, pad_out, pad_oe, pad_pu, pad_in_en, pin_edge;
  int          err_count = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          sg[7]     = '{4, 5, 6, 7, 8, 9, 10};
  int          p4[7]     = '{2, 3, 6, 7, 8, 9, 10};
  int          p3[7]     = '{2, 3, 6, -1, 7, 8, 9};

  pcx_priority_pin_crossbar i_dut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pin_skip_mask(skip),
    .pin_input_kind(in_kind), .pin_drive_kind(drv_kind), .slave_select_mode(ssm), .gpio_out(gpio_out),
    .gpio_in(gpio_in), .periph_out(p_out), .periph_oe(p_oe), .periph_in(periph_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu), .pad_in_en(pad_in_en), .pin_edge(pin_edge)
  );
  pcx_pad_model i_pads (
    .core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd   <= 1'b0;
    #1;
    `CHK("sfr_rdata", e, sfr_rdata)
  endtask

  // Target signal drives 0, everything else 1; only the target pin shows a driven low
  task automatic map(input int sig, input int pin);
    logic [31:0] e;
    @(posedge core_clk);
    p_out <= ~(16'h1 << sig);
    settle();
    e = (pin < 0) ? 32'h0 : (32'h1 << pin);
    `CHK("pin map", e, ~pad_out & pad_oe)
  endtask

  task automatic t_reset;
    rd_chk(ADDR_ROUTE_A, ROUTE_A_RESET);
    rd_chk(ADDR_ROUTE_C, ROUTE_C_RESET);
    `CHK("pad_oe", 32'h0, pad_oe)
    `CHK("pad_in_en", 32'hffffffff, pad_in_en)
    `CHK("periph_in", 16'hffff, periph_in)
  endtask

  task automatic t_regs;
    wr(ADDR_ROUTE_A, 8'hff);
    rd_chk(ADDR_ROUTE_A, 8'hff);
    wr(ADDR_ROUTE_C, 8'hff);
    rd_chk(ADDR_ROUTE_C, 8'hc1);
    rd_chk(8'h10, 8'h00);
    wr(ADDR_ROUTE_C, 8'h00);
    wr(ADDR_ROUTE_A, 8'h00);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_ROUTE_A, 8'h5a);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd_chk(ADDR_ROUTE_A, 8'h00);
  endtask

  task automatic t_fixed;
    wr(ADDR_ROUTE_A, 8'h01);
    settle();
    `CHK("pad_oe off", 32'h0, pad_oe)
    wr(ADDR_ROUTE_C, 8'h40);
    settle();
    `CHK("gpio drive", 1'b1, pad_oe[20])
    map(SIG_UART_TX, PIN_UART_TX);
    `CHK("uart rx", 1'b0, periph_in[SIG_UART_RX])
    wr(ADDR_ROUTE_A, 8'h02);
    map(SIG_CAN_TX, PIN_CAN_TX);
    map(SIG_UART_TX, -1);
  endtask

  task automatic t_prio;
    @(posedge core_clk);
    skip <= 32'h3;
    wr(ADDR_ROUTE_A, 8'h1d);
    for (int i = 0; i < 7; i++) begin
      map(sg[i], p4[i]);
    end
    @(posedge core_clk);
    ssm <= SSM_THREE_WIRE;
    for (int i = 0; i < 7; i++) begin
      map(sg[i], p3[i]);
    end
    @(posedge core_clk);
    skip <= ~(32'h1 << 31);
    wr(ADDR_ROUTE_A, 8'h08);
    map(SIG_SMB_SDA, -1);
    @(posedge core_clk);
    skip <= ~(32'h3 << 30);
    map(SIG_SMB_SDA, 30);
  endtask

  task automatic t_pull;
    @(posedge core_clk);
    skip     <= 32'h0;
    p_out    <= '1;
    in_kind  <= ~32'h808;
    drv_kind <= ~32'h800;
    gpio_out <= ~32'h8;
    ext_val  <= 32'h800;
    settle();
    `CHK("analog pins", 4'h0, {pad_oe[3], pad_pu[11], pad_in_en[3], gpio_in[11]})
    `CHK("smbus high", 2'b01, {pad_oe[0], pad_pu[0]})
    `CHK("push-pull pu", 1'b0, pad_pu[2])
    @(posedge core_clk);
    p_out[SIG_SMB_SDA] <= 1'b0;
    settle();
    `CHK("smbus low", 3'b100, {pad_oe[0], pad_out[0], pad_pu[0]})
    wr(ADDR_ROUTE_C, 8'hc0);
    settle();
    `CHK("pu disabled", 1'b0, pad_pu[1])
  endtask

  task automatic t_edge;
    logic [3:0] n12;
    logic [3:0] n13;
    n12 = 4'h0;
    n13 = 4'h0;
    @(posedge core_clk);
    skip     <= 32'h1000;
    in_kind  <= ~32'h2000;
    drv_kind <= ~32'h3000;
    gpio_out <= '1;
    settle();
    @(posedge core_clk);
    ext_val <= ext_val ^ 32'h3000;
    repeat (6) begin
      @(posedge core_clk);
      #1;
      n12 = n12 + 4'(pin_edge[12]);
      n13 = n13 + 4'(pin_edge[13]);
    end
    `CHK("edge digital", 4'h1, n12)
    `CHK("edge analog", 4'h0, n13)
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_fixed();
    t_prio();
    t_pull();
    t_edge();
    tally_and_finish();
  end
endmodule
